// [pci_pkg.sv]
// Purpose: Constants and carrier types for the panel/CPU shared interface area.
// Assumes: Registers are word-indexed; byte address is four times the index.
// Notes: All offsets below are register indices, not byte addresses.
// Summary of operation
// - Handshake bit 0 marks the mailbox locked; only the panel ever sets it.
// - CPU acknowledges a transfer with bit 1 for error or bit 2 for success.
// - Panel sets handshake bit 3 once a record transfer has finished.
// - Job area is four 16-bit words: job number then three parameters.
// - A non-zero job number is executed, then cleared to zero by the panel.
// - Panel writes its coupling identifier into its own byte.
// - Time field holds hours, minutes and seconds, one byte each.
// - Date field holds weekday, day, month and year, one byte each.
// - All time and date bytes are binary-coded decimal.
// - Date and time are copied in only when job 41 runs.
// - Direct transfer writes each variable to its address when below MW; unaddressed and out-of-range ones are skipped.
// - Indirect transfer puts values only, no addresses, into the mailbox.
// - For an indirect read the CPU fills the mailbox before the panel reads.
// - Panel aborts a transfer if already locked, otherwise it sets the lock (only in ST_IDLE; an unlocked start in another state is dropped).
// - On a lock request the panel sets the lock and clears the request together.
`default_nettype none
package pci_pkg;
   // =====================================================================
   // Register indices
   localparam logic [7:0] IDX_HSK = 8'h03;
   localparam logic [7:0] IDX_JOB_NUM = 8'h04;
   localparam logic [7:0] IDX_JOB_P1 = 8'h06;
   localparam logic [7:0] IDX_JOB_P2 = 8'h08;
   localparam logic [7:0] IDX_JOB_P3 = 8'h0A;
   localparam logic [7:0] IDX_CPL = 8'h0D;
   localparam logic [7:0] IDX_HOURS = 8'h0F;
   localparam logic [7:0] IDX_MINUTES = 8'h10;
   localparam logic [7:0] IDX_SECONDS = 8'h11;
   localparam logic [7:0] IDX_WEEKDAY = 8'h15;
   localparam logic [7:0] IDX_DAY = 8'h16;
   localparam logic [7:0] IDX_MONTH = 8'h17;
   localparam logic [7:0] IDX_YEAR = 8'h18;
   localparam logic [7:0] IDX_STATUS = 8'h1C;
   localparam logic [7:0] IDX_MBOX = 8'h20;
   // =====================================================================
   // Handshake bit positions
   localparam int HB_LOCKED = 0;
   localparam int HB_ERR = 1;
   localparam int HB_OK = 2;
   localparam int HB_DONE = 3;
   localparam int HB_REQ = 4;
   localparam int HB_READ = 5;
   localparam int HB_LOCKREQ = 6;
   localparam logic [7:0] HSK_RESET = 8'h00;
   localparam logic [15:0] JOB_DATE_TIME = 16'h0029;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // =====================================================================
   // Types
   typedef enum logic [2:0] {ST_IDLE, ST_LOCKED, ST_FILL, ST_WAIT_ACK, ST_READ} pci_state_t;
   typedef struct packed {
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
      logic [7:0] weekday;
      logic [7:0] day;
      logic [7:0] month;
      logic [7:0] year;
   } pci_clock_t;
   typedef struct packed {
      logic [15:0] number;
      logic [15:0] p1;
      logic [15:0] p2;
      logic [15:0] p3;
   } pci_job_t;
   typedef struct packed {
      logic [15:0] value;
      logic [7:0] addr;
      logic addr_ok;
      logic last;
   } pci_rec_t;
endpackage
`default_nettype wire

// [pci_area.sv]
// Purpose: Panel-side logic of the shared interface area, reached by the CPU over AXI4-Lite.
// Assumes: Panel user logic runs on core_clk; the CPU is the AXI4-Lite master.
// Notes: The mailbox also serves as the variable area for direct transfers.
`timescale 1ns/100ps
`default_nettype none
module pci_area #(
   parameter int MW = 16,
   parameter logic [7:0] COUPLING_ID = 8'h5A // Arbitrary value.
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [9:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic job_valid,
   input wire logic job_ready,
   output pci_pkg::pci_job_t job_data,
   input wire pci_pkg::pci_clock_t rtc_now,
   input wire logic xfer_start,
   input wire logic xfer_direct,
   output logic xfer_abort,
   output logic xfer_done,
   output logic xfer_err,
   output logic fetch_req,
   output logic [15:0] fetch_id,
   input wire logic rec_valid,
   output logic rec_ready,
   input wire pci_pkg::pci_rec_t rec_in,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [15:0] rd_data,
   output logic rd_last
);
   localparam int PW = $clog2(MW);
   // =====================================================================
   // State
   typedef struct packed {
      pci_pkg::pci_state_t st;
      logic [7:0] hsk;
      pci_pkg::pci_job_t job;
      logic [7:0] cpl;
      logic cpl_loaded;
      pci_pkg::pci_clock_t clk;
      logic bcd_rejected;
      logic [MW-1:0][15:0] mbox;
      logic [PW-1:0] ptr;
      logic direct;
      logic aw_v;
      logic [7:0] aw_idx;
      logic w_v;
      logic [15:0] w_data;
      logic [1:0] w_strb;
      logic bv;
      logic [1:0] bresp;
      logic rv;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic abort_p;
      logic done_p;
      logic err_p;
      logic fetch_p;
   } pci_reg_t;
   pci_reg_t s_q;
   pci_reg_t s_d;
   logic wr_fire;
   logic job_take;
   logic [7:0] r_off;
   logic [7:0] w_off;
   logic r_hit;
   logic w_hit;
   // =====================================================================
   // Helpers
   function automatic logic bcd_ok(input logic [7:0] v);
      bcd_ok = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
   endfunction
   function automatic logic clock_ok(input pci_pkg::pci_clock_t c);
      clock_ok = bcd_ok(c.hours) && bcd_ok(c.minutes) && bcd_ok(c.seconds) &&
         bcd_ok(c.weekday) && bcd_ok(c.day) && bcd_ok(c.month) && bcd_ok(c.year);
   endfunction
   assign wr_fire = s_q.aw_v && s_q.w_v && !s_q.bv;
   assign job_take = job_valid && job_ready;
   assign r_off = s_axi_araddr[9:2] - pci_pkg::IDX_MBOX;
   assign w_off = s_q.aw_idx - pci_pkg::IDX_MBOX;
   assign r_hit = (s_axi_araddr[9:2] >= pci_pkg::IDX_MBOX) && (r_off < 8'(MW));
   assign w_hit = (s_q.aw_idx >= pci_pkg::IDX_MBOX) && (w_off < 8'(MW));
   // =====================================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.abort_p = 1'b0;
      s_d.done_p = 1'b0;
      s_d.err_p = 1'b0;
      s_d.fetch_p = 1'b0;
      // Identifier is loaded on the first edge after reset release.
      if (!s_q.cpl_loaded) begin
         s_d.cpl = COUPLING_ID;
         s_d.cpl_loaded = 1'b1;
      end
      // Consumption clears first so a CPU write in the same cycle wins.
      if (job_take) begin
         s_d.job.number = 16'h0000;
         if (s_q.job.number == pci_pkg::JOB_DATE_TIME) begin
            if (clock_ok(rtc_now)) begin
               s_d.clk = rtc_now;
            end
         end
      end
      // Write channel.
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_v = 1'b1;
         s_d.aw_idx = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_v = 1'b1;
         s_d.w_data = s_axi_wdata[15:0];
         s_d.w_strb = s_axi_wstrb[1:0];
      end
      if (s_q.bv && s_axi_bready) begin
         s_d.bv = 1'b0;
      end
      if (wr_fire) begin
         s_d.aw_v = 1'b0;
         s_d.w_v = 1'b0;
         s_d.bv = 1'b1;
         s_d.bresp = pci_pkg::RESP_OKAY;
         case (s_q.aw_idx)
            pci_pkg::IDX_HSK: begin
               if (s_q.w_strb[0]) begin
                  // CPU may release the lock but never take it.
                  s_d.hsk[pci_pkg::HB_LOCKED] = s_q.hsk[0] & s_q.w_data[0];
                  s_d.hsk[2:1] = s_q.w_data[2:1];
                  s_d.hsk[6:4] = s_q.w_data[6:4];
               end
            end
            pci_pkg::IDX_JOB_NUM: begin
               // Parameters are not captured here; job_data shows their current values until the job is taken.
               if (s_q.w_strb[0]) s_d.job.number[7:0] = s_q.w_data[7:0];
               if (s_q.w_strb[1]) s_d.job.number[15:8] = s_q.w_data[15:8];
            end
            pci_pkg::IDX_JOB_P1: begin
               if (s_q.w_strb[0]) s_d.job.p1[7:0] = s_q.w_data[7:0];
               if (s_q.w_strb[1]) s_d.job.p1[15:8] = s_q.w_data[15:8];
            end
            pci_pkg::IDX_JOB_P2: begin
               if (s_q.w_strb[0]) s_d.job.p2[7:0] = s_q.w_data[7:0];
               if (s_q.w_strb[1]) s_d.job.p2[15:8] = s_q.w_data[15:8];
            end
            pci_pkg::IDX_JOB_P3: begin
               if (s_q.w_strb[0]) s_d.job.p3[7:0] = s_q.w_data[7:0];
               if (s_q.w_strb[1]) s_d.job.p3[15:8] = s_q.w_data[15:8];
            end
            pci_pkg::IDX_STATUS: begin
               if (s_q.w_strb[0] && s_q.w_data[7]) s_d.bcd_rejected = 1'b0;
            end
            pci_pkg::IDX_CPL, pci_pkg::IDX_HOURS, pci_pkg::IDX_MINUTES,
            pci_pkg::IDX_SECONDS, pci_pkg::IDX_WEEKDAY, pci_pkg::IDX_DAY,
            pci_pkg::IDX_MONTH, pci_pkg::IDX_YEAR: begin
               s_d.bresp = pci_pkg::RESP_OKAY;
            end
            default: begin
               if (w_hit) begin
                  if (s_q.w_strb[0]) s_d.mbox[w_off[PW-1:0]][7:0] = s_q.w_data[7:0];
                  if (s_q.w_strb[1]) s_d.mbox[w_off[PW-1:0]][15:8] = s_q.w_data[15:8];
               end else begin
                  s_d.bresp = pci_pkg::RESP_SLVERR;
               end
            end
         endcase
      end
      // A rejected time sample beats a status clear in the same cycle.
      if (job_take && (s_q.job.number == pci_pkg::JOB_DATE_TIME) && !clock_ok(rtc_now)) begin
         s_d.bcd_rejected = 1'b1;
      end
      // Read channel.
      if (s_q.rv && s_axi_rready) begin
         s_d.rv = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rv = 1'b1;
         s_d.rresp = pci_pkg::RESP_OKAY;
         s_d.rdata = 32'h00000000;
         case (s_axi_araddr[9:2])
            pci_pkg::IDX_HSK: s_d.rdata[7:0] = s_q.hsk;
            pci_pkg::IDX_JOB_NUM: s_d.rdata[15:0] = s_q.job.number;
            pci_pkg::IDX_JOB_P1: s_d.rdata[15:0] = s_q.job.p1;
            pci_pkg::IDX_JOB_P2: s_d.rdata[15:0] = s_q.job.p2;
            pci_pkg::IDX_JOB_P3: s_d.rdata[15:0] = s_q.job.p3;
            pci_pkg::IDX_CPL: s_d.rdata[7:0] = s_q.cpl;
            pci_pkg::IDX_HOURS: s_d.rdata[7:0] = s_q.clk.hours;
            pci_pkg::IDX_MINUTES: s_d.rdata[7:0] = s_q.clk.minutes;
            pci_pkg::IDX_SECONDS: s_d.rdata[7:0] = s_q.clk.seconds;
            pci_pkg::IDX_WEEKDAY: s_d.rdata[7:0] = s_q.clk.weekday;
            pci_pkg::IDX_DAY: s_d.rdata[7:0] = s_q.clk.day;
            pci_pkg::IDX_MONTH: s_d.rdata[7:0] = s_q.clk.month;
            pci_pkg::IDX_YEAR: s_d.rdata[7:0] = s_q.clk.year;
            pci_pkg::IDX_STATUS: s_d.rdata[7:0] = {s_q.bcd_rejected, 4'h0, s_q.st};
            default: begin
               if (r_hit) begin
                  s_d.rdata[15:0] = s_q.mbox[r_off[PW-1:0]];
               end else begin
                  s_d.rresp = pci_pkg::RESP_SLVERR;
               end
            end
         endcase
      end
      // A start while the mailbox is locked is refused in every state, never queued.
      if (xfer_start && s_q.hsk[pci_pkg::HB_LOCKED]) begin
         s_d.abort_p = 1'b1;
      end
      // Transfer sequencer; its updates follow the CPU write so panel sets win.
      case (s_q.st)
         pci_pkg::ST_IDLE: begin
            if (xfer_start) begin
               if (s_q.hsk[pci_pkg::HB_LOCKED]) begin
                  s_d.abort_p = 1'b1;
               end else begin
                  s_d.hsk[pci_pkg::HB_LOCKED] = 1'b1;
                  s_d.direct = xfer_direct;
                  s_d.ptr = '0;
                  s_d.st = pci_pkg::ST_FILL;
               end
            end else if (s_q.hsk[pci_pkg::HB_LOCKREQ] && !s_q.hsk[pci_pkg::HB_LOCKED]) begin
               s_d.hsk[pci_pkg::HB_LOCKED] = 1'b1;
               s_d.hsk[pci_pkg::HB_LOCKREQ] = 1'b0;
               s_d.st = pci_pkg::ST_LOCKED;
            end else if (s_q.hsk[pci_pkg::HB_READ]) begin
               s_d.ptr = '0;
               s_d.st = pci_pkg::ST_READ;
            end
         end
         pci_pkg::ST_LOCKED: begin
            if (s_q.hsk[pci_pkg::HB_REQ]) begin
               s_d.hsk[pci_pkg::HB_REQ] = 1'b0;
               s_d.fetch_p = 1'b1;
               s_d.direct = xfer_direct;
               s_d.ptr = '0;
               s_d.st = pci_pkg::ST_FILL;
            end else if (!s_q.hsk[pci_pkg::HB_LOCKED]) begin
               s_d.st = pci_pkg::ST_IDLE;
            end
         end
         pci_pkg::ST_FILL: begin
            if (rec_valid) begin
               if (s_q.direct) begin
                  if (rec_in.addr_ok && (rec_in.addr < 8'(MW))) begin
                     s_d.mbox[rec_in.addr[PW-1:0]] = rec_in.value;
                  end
               end else begin
                  s_d.mbox[s_q.ptr] = rec_in.value;
                  s_d.ptr = s_q.ptr + 1'b1;
               end
               if (rec_in.last) begin
                  s_d.hsk[pci_pkg::HB_DONE] = 1'b1;
                  s_d.st = pci_pkg::ST_WAIT_ACK;
               end
            end
         end
         pci_pkg::ST_WAIT_ACK: begin
            // The lock release by the CPU, with the error or success bit set, closes the exchange.
            if (!s_q.hsk[pci_pkg::HB_LOCKED] && (s_q.hsk[pci_pkg::HB_ERR] || s_q.hsk[pci_pkg::HB_OK])) begin
               s_d.hsk[3:1] = 3'h0;
               s_d.done_p = 1'b1;
               s_d.err_p = s_q.hsk[pci_pkg::HB_ERR];
               s_d.st = pci_pkg::ST_IDLE;
            end
         end
         pci_pkg::ST_READ: begin
            if (rd_ready) begin
               s_d.ptr = s_q.ptr + 1'b1;
               if (rd_last) begin
                  s_d.hsk[pci_pkg::HB_READ] = 1'b0;
                  s_d.st = pci_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            s_d.st = pci_pkg::ST_IDLE;
         end
      endcase
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   // =====================================================================
   // Outputs
   assign s_axi_awready = !s_q.aw_v;
   assign s_axi_wready = !s_q.w_v;
   assign s_axi_bvalid = s_q.bv;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rv;
   assign s_axi_rvalid = s_q.rv;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign job_valid = (s_q.job.number != 16'h0000);
   assign job_data = s_q.job;
   assign xfer_abort = s_q.abort_p;
   assign xfer_done = s_q.done_p;
   assign xfer_err = s_q.err_p;
   assign fetch_req = s_q.fetch_p;
   assign fetch_id = s_q.mbox[0];
   assign rec_ready = (s_q.st == pci_pkg::ST_FILL);
   assign rd_valid = (s_q.st == pci_pkg::ST_READ);
   assign rd_data = s_q.mbox[s_q.ptr];
   assign rd_last = (s_q.ptr == PW'(MW - 1));
   // =====================================================================
   // Checks
   logic hsk_wr;
   assign hsk_wr = wr_fire && (s_q.aw_idx == pci_pkg::IDX_HSK);
   a_job_consume: assert property (@(posedge core_clk) disable iff (rst)
      job_take && !(wr_fire && s_q.aw_idx == pci_pkg::IDX_JOB_NUM) |=> !job_valid)
      else $error("job number not cleared after consumption");
   a_lock_abort: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == pci_pkg::ST_IDLE && xfer_start && s_q.hsk[0] |=> xfer_abort && s_q.st == pci_pkg::ST_IDLE)
      else $error("locked mailbox did not abort transfer");
   a_lock_take: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == pci_pkg::ST_IDLE && xfer_start && !s_q.hsk[0] |=> s_q.hsk[0] && rec_ready)
      else $error("free mailbox not locked on transfer start");
   a_lock_grant: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == pci_pkg::ST_IDLE && !xfer_start && s_q.hsk[6] && !s_q.hsk[0] && !hsk_wr
      |=> s_q.hsk[0] && !s_q.hsk[6])
      else $error("lock request not granted in one update");
   a_lock_owner: assert property (@(posedge core_clk) disable iff (rst)
      $rose(s_q.hsk[0]) |-> $past(s_q.st) == pci_pkg::ST_IDLE)
      else $error("lock bit rose outside panel grant");
   a_done_flag: assert property (@(posedge core_clk) disable iff (rst)
      rec_valid && rec_ready && rec_in.last |=> s_q.hsk[3] ##0 s_q.st == pci_pkg::ST_WAIT_ACK)
      else $error("done bit not set after last record word");
   a_skip_unaddr: assert property (@(posedge core_clk) disable iff (rst)
      rec_valid && rec_ready && s_q.direct && !rec_in.addr_ok && !wr_fire |=> $stable(s_q.mbox))
      else $error("unaddressed variable was stored");
   a_ack_close: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == pci_pkg::ST_WAIT_ACK && !s_q.hsk[0] && (s_q.hsk[1] || s_q.hsk[2]) && !hsk_wr
      |=> xfer_done && s_q.hsk[3:1] == 3'h0 ##1 !xfer_done)
      else $error("acknowledge did not close transfer");
   a_clock_bcd: assert property (@(posedge core_clk) disable iff (rst)
      clock_ok(s_q.clk))
      else $error("time or date field not BCD");
   a_date_job: assert property (@(posedge core_clk) disable iff (rst)
      !$stable(s_q.clk) |-> $past(job_take && s_q.job.number == pci_pkg::JOB_DATE_TIME))
      else $error("clock fields changed without date job");
   a_cpl_value: assert property (@(posedge core_clk) disable iff (rst)
      s_q.cpl_loaded |-> s_q.cpl == COUPLING_ID)
      else $error("coupling identifier wrong");
   // The broader form also catches a start that arrives mid-exchange.
   a_busy_abort: assert property (@(posedge core_clk) disable iff (rst)
      xfer_start && s_q.hsk[0] |=> xfer_abort)
      else $error("start while locked was not refused");
   c_lock_abort: cover property (@(posedge core_clk) disable iff (rst) xfer_abort);
   c_job_run: cover property (@(posedge core_clk) disable iff (rst) job_take);
   c_xfer_ok: cover property (@(posedge core_clk) disable iff (rst) xfer_done && !xfer_err);
   c_fetch: cover property (@(posedge core_clk) disable iff (rst) fetch_req);
   c_read_out: cover property (@(posedge core_clk) disable iff (rst) rd_valid && rd_ready && rd_last);
endmodule // pci_area
`default_nettype wire

// [pci_panel_model.sv]
// Purpose: Panel user logic facing the shared area: job taker, record source, read sink.
// Assumes: Records are offered back to back; the job taker answers slowly.
// Notes: Record i carries value A000+i at word 5+i; record 1 has no address.
`timescale 1ns/100ps
`default_nettype none
module pci_panel_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic job_valid,
   input wire logic rec_ready,
   input wire logic rd_valid,
   output logic job_ready,
   output logic rec_valid,
   output logic rd_ready,
   output pci_pkg::pci_rec_t rec_in
);
   // =====================================================================
   // State
   logic [1:0] wait_q;
   logic [1:0] idx_q;
   logic stall_q;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wait_q <= 2'h0;
         idx_q <= 2'h0;
         stall_q <= 1'b0;
      end else begin
         wait_q <= (job_valid && !job_ready) ? wait_q + 2'h1 : 2'h0;
         stall_q <= !stall_q;
         if (rec_valid && rec_ready) begin
            idx_q <= (idx_q == 2'h2) ? 2'h0 : idx_q + 2'h1;
         end
      end
   end
   // A slow taker shows that a job stays posted until it is consumed.
   assign job_ready = (wait_q == 2'h3);
   assign rd_ready = stall_q;
   assign rec_valid = !rst;
   assign rec_in.value = 16'hA000 + {14'h0, idx_q};
   assign rec_in.addr = 8'h05 + {6'h0, idx_q};
   assign rec_in.addr_ok = (idx_q != 2'h1);
   assign rec_in.last = (idx_q == 2'h2);
endmodule // pci_panel_model
`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench for the shared interface area.
// Assumes: The bench is the CPU on AXI4-Lite; the panel side is the model.
// Notes: Busy outputs are polled over the bus with a bounded count.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic core_clk, rst, awvalid, wvalid, bready, arvalid, rready, xfer_start, xfer_direct;
   logic awready, wready, bvalid, arready, rvalid, job_valid, job_ready, xfer_abort;
   logic xfer_done, xfer_err, fetch_req, rec_valid, rec_ready, rd_valid, rd_ready, rd_last;
   logic [9:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [15:0] rd_data, fetch_id;
   logic [15:0] rd_x = 16'h0000;
   int n_fetch = 0;
   pci_pkg::pci_job_t job_data;
   pci_pkg::pci_clock_t rtc_now;
   pci_pkg::pci_rec_t rec_in;
   int miscompares = 0, total_checks = 0, n_done = 0, n_err = 0, n_abort = 0, n_rd = 0, n_last = 0;
   pci_area DUT (.core_clk(core_clk), .rst(rst), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .job_valid(job_valid),
      .job_ready(job_ready), .job_data(job_data), .rtc_now(rtc_now), .xfer_start(xfer_start),
      .xfer_direct(xfer_direct), .xfer_abort(xfer_abort), .xfer_done(xfer_done),
      .xfer_err(xfer_err), .fetch_req(fetch_req), .fetch_id(fetch_id), .rec_valid(rec_valid),
      .rec_ready(rec_ready), .rec_in(rec_in), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .rd_last(rd_last));
   pci_panel_model panel (.core_clk(core_clk), .rst(rst), .job_valid(job_valid),
      .rec_ready(rec_ready), .rd_valid(rd_valid), .job_ready(job_ready),
      .rec_valid(rec_valid), .rd_ready(rd_ready), .rec_in(rec_in));
   // =====================================================================
   // Clock, monitors and checking
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      n_done += xfer_done;
      n_err += xfer_err;
      n_abort += xfer_abort;
      n_rd += (rd_valid && rd_ready);
      n_last += (rd_valid && rd_ready && rd_last);
      n_fetch += fetch_req;
      if (rd_valid && rd_ready) rd_x ^= rd_data;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // =====================================================================
   // Bus master
   task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
      logic a, w;
      a = 1'b1;
      w = 1'b1;
      @(posedge core_clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= {i, 2'b00};
      wdata <= d;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (a && awready) begin a = 1'b0; awvalid <= 1'b0; end
         if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
      end while (a || w);
      do @(posedge core_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, er);
   endtask
   task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      arvalid <= 1'b1;
      araddr <= {i, 2'b00};
      rready <= 1'b1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // Polls until the masked value matches, then compares it.
   task automatic poll(input logic [7:0] i, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      do begin rd(i, d, r); n++; end while (((d & m) !== e) && n < 60);
      chk(d & m, e);
   endtask
   // =====================================================================
   // Scenarios
   task automatic t_jobs();
      rtc_now <= '{8'h23, 8'h59, 8'h07, 8'h07, 8'h31, 8'h12, 8'h99};
      poll(pci_pkg::IDX_CPL, 32'hFF, 32'h5A);
      wr(pci_pkg::IDX_JOB_P1, 32'h0011, pci_pkg::RESP_OKAY);
      wr(pci_pkg::IDX_JOB_P3, 32'h0033, pci_pkg::RESP_OKAY);
      wr(pci_pkg::IDX_JOB_NUM, 32'h0007, pci_pkg::RESP_OKAY);
      do @(posedge core_clk); while (job_valid !== 1'b1);
      chk(job_data[63:32], 32'h0007_0011);
      chk(job_data[31:0], 32'h0000_0033);
      poll(pci_pkg::IDX_JOB_NUM, 32'hFFFF, 32'h0);
      poll(pci_pkg::IDX_HOURS, 32'hFF, 32'h0);
      wr(pci_pkg::IDX_JOB_NUM, 32'h0029, pci_pkg::RESP_OKAY);
      poll(pci_pkg::IDX_JOB_NUM, 32'hFFFF, 32'h0);
      poll(pci_pkg::IDX_HOURS, 32'hFF, 32'h23);
      poll(pci_pkg::IDX_SECONDS, 32'hFF, 32'h07);
      poll(pci_pkg::IDX_WEEKDAY, 32'hFF, 32'h07);
      poll(pci_pkg::IDX_YEAR, 32'hFF, 32'h99);
      rtc_now <= '{8'h1A, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
      wr(pci_pkg::IDX_JOB_NUM, 32'h0029, pci_pkg::RESP_OKAY);
      poll(pci_pkg::IDX_JOB_NUM, 32'hFFFF, 32'h0);
      poll(pci_pkg::IDX_HOURS, 32'hFF, 32'h23);
      poll(pci_pkg::IDX_STATUS, 32'h80, 32'h80);
      wr(pci_pkg::IDX_STATUS, 32'h80, pci_pkg::RESP_OKAY);
      poll(pci_pkg::IDX_STATUS, 32'hFF, 32'h00);
   endtask
   task automatic t_indirect();
      @(posedge core_clk);
      xfer_start <= 1'b1;
      @(posedge core_clk);
      xfer_start <= 1'b0;
      poll(pci_pkg::IDX_HSK, 32'h09, 32'h09);
      poll(pci_pkg::IDX_MBOX + 8'h2, 32'hFFFF, 32'hA002);
      wr(pci_pkg::IDX_HSK, 32'h04, pci_pkg::RESP_OKAY);
      poll(pci_pkg::IDX_HSK, 32'hFF, 32'h00);
      chk(n_done, 1);
   endtask
   task automatic t_lock_direct();
      wr(pci_pkg::IDX_MBOX + 8'h6, 32'h1234, pci_pkg::RESP_OKAY);
      wr(pci_pkg::IDX_HSK, 32'h40, pci_pkg::RESP_OKAY);
      poll(pci_pkg::IDX_HSK, 32'hFF, 32'h01);
      @(posedge core_clk);
      xfer_start <= 1'b1;
      @(posedge core_clk);
      xfer_start <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(n_abort, 1);
      xfer_direct <= 1'b1;
      wr(pci_pkg::IDX_HSK, 32'h11, pci_pkg::RESP_OKAY);
      poll(pci_pkg::IDX_HSK, 32'h19, 32'h09);
      chk(n_fetch, 1);
      chk(fetch_id, 32'hA000);
      poll(pci_pkg::IDX_MBOX + 8'h7, 32'hFFFF, 32'hA002);
      poll(pci_pkg::IDX_MBOX + 8'h6, 32'hFFFF, 32'h1234);
      wr(pci_pkg::IDX_HSK, 32'h02, pci_pkg::RESP_OKAY);
      poll(pci_pkg::IDX_HSK, 32'hFF, 32'h00);
      chk(n_err, 1);
   endtask
   task automatic t_read();
      logic [31:0] d;
      logic [1:0] r;
      wr(pci_pkg::IDX_HSK, 32'h20, pci_pkg::RESP_OKAY);
      poll(pci_pkg::IDX_HSK, 32'h20, 32'h00);
      chk(n_rd, 16);
      chk(n_last, 1);
      chk(rd_x, 32'hB235);
      wr(8'h01, 32'h0, pci_pkg::RESP_SLVERR);
      rd(8'h02, d, r);
      chk(r, pci_pkg::RESP_SLVERR);
      chk(d, 32'h0);
   endtask
   // =====================================================================
   // Main sequence and watchdog
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready, xfer_start, xfer_direct} = 8'h80;
      {awaddr, araddr, wdata, wstrb} = {10'h0, 10'h0, 32'h0, 4'hF};
      rtc_now = '0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      t_jobs();
      t_indirect();
      t_lock_direct();
      t_read();
      complete_run();
   end
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end
endmodule // tb
`default_nettype wire
